// ==== src/dtmfhs_status_bank.sv ====
// Purpose: Host register bank with status flags, control registers and burst timer
// Assumes: Receiver event inputs are single-cycle pulses on clk_i
// Notes: Strobes are edge-detected after synchronising, so each access costs a few clocks
`timescale 1ns/100ps
module dtmfhs_status_bank
    import dtmfhs_pkg::*;
#(
    parameter int BURST_CYC = DTMFHS_BURST_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic register_select_input_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [3:0] data_i,
    output logic [3:0] data_o,
    output logic data_oe_n_o,
    input wire logic rx_valid_i,
    input wire logic [3:0] rx_code_i,
    input wire logic tone_absent_i,
    input wire logic tone_valid_i,
    input wire logic cp_square_i,
    output logic irq_n_o,
    output logic tone_output_enable_o,
    output logic [3:0] tx_code_o,
    output logic call_progress_mode_o
);
    dtmfhs_state_s s_r;
    dtmfhs_state_s s_nxt;
    logic rd_start, rd_end, wr_end, burst_on, tx_set, rx_set;
    logic [3:0] clr;
    logic [DTMFHS_CNT_W-1:0] lim;

    function automatic logic rise(input logic prev, input logic cur);
        rise = ~prev & cur;
    endfunction : rise

    assign rd_start = rise(s_r.rd_s, s_r.rd_d);
    assign rd_end = rise(s_r.rd_d, s_r.rd_s);
    assign wr_end = rise(s_r.wr_d, s_r.wr_s);
    assign burst_on = ~s_r.crb[CRB_BURST_N];
    // Call progress mode doubles burst and pause length
    assign lim = s_r.cra[CRA_CP_MODE] ? DTMFHS_CNT_W'(2 * BURST_CYC - 1) : DTMFHS_CNT_W'(BURST_CYC - 1);
    assign rx_set = rx_valid_i & ~s_r.cra[CRA_CP_MODE];
    assign tx_set = (s_r.bst == BST_PAUSE) && (s_r.cnt == lim);
    // Only flags the host actually saw are cleared, so late events survive
    assign clr = (rd_end && s_r.read_status) ? s_r.snap : 4'h0;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rs_m = register_select_input_i;
        s_nxt.rs_s = s_r.rs_m;
        s_nxt.rd_m = rd_n_i;
        s_nxt.rd_s = s_r.rd_m;
        s_nxt.rd_d = s_r.rd_s;
        s_nxt.wr_m = wr_n_i;
        s_nxt.wr_s = s_r.wr_m;
        s_nxt.wr_d = s_r.wr_s;
        s_nxt.d_m = data_i;
        s_nxt.d_s = s_r.d_m;
        if (rd_start) begin
            s_nxt.read_status = s_r.rs_s;
            s_nxt.snap = s_r.flags;
            s_nxt.dout = s_r.rs_s ? s_r.flags : s_r.rx_data;
            s_nxt.dout_oe_n = 1'b0;
        end else if (rd_end) begin
            s_nxt.dout_oe_n = 1'b1;
            s_nxt.read_status = 1'b0;
        end
        if (wr_end && s_r.rs_s) begin
            if (s_r.bank_b) begin
                s_nxt.crb = s_r.d_s;
                s_nxt.bank_b = 1'b0;
            end else begin
                s_nxt.cra = s_r.d_s;
                s_nxt.bank_b = s_r.d_s[CRA_BANK_SEL];
            end
        end
        case (s_r.bst)
            BST_IDLE: begin
                s_nxt.cnt = '0;
            end
            BST_TONE: begin
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (s_r.cnt == lim) begin
                    s_nxt.bst = BST_PAUSE;
                    s_nxt.cnt = '0;
                end
            end
            BST_PAUSE: begin
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (s_r.cnt == lim) begin
                    s_nxt.bst = BST_IDLE;
                    s_nxt.cnt = '0;
                end
            end
            default: begin
                s_nxt.bst = BST_IDLE;
            end
        endcase
        if (!burst_on) begin
            s_nxt.bst = BST_IDLE;
        end
        if (wr_end && !s_r.rs_s) begin
            s_nxt.tx_code = s_r.d_s;
            if (burst_on && s_r.cra[CRA_TONE_OUT]) begin
                s_nxt.bst = BST_TONE;
                s_nxt.cnt = '0;
            end
        end
        if (rx_set) begin
            s_nxt.rx_data = rx_code_i;
        end
        // Set wins over the read-clear on the transmit-empty, receive-full and interrupt flags
        s_nxt.flags[ST_TX_EMPTY] = burst_on & ((s_r.flags[ST_TX_EMPTY] & ~clr[ST_TX_EMPTY]) | tx_set);
        s_nxt.flags[ST_RX_FULL] = (s_r.flags[ST_RX_FULL] & ~clr[ST_RX_FULL]) | rx_set;
        s_nxt.flags[ST_IRQ] = (s_r.flags[ST_IRQ] & ~clr[ST_IRQ]) | s_nxt.flags[ST_TX_EMPTY]
            | s_nxt.flags[ST_RX_FULL];
        if (tone_absent_i) begin
            s_nxt.flags[ST_TONE_ABSENT] = 1'b1;
        end else if (tone_valid_i) begin
            s_nxt.flags[ST_TONE_ABSENT] = 1'b0;
        end
        s_nxt.tone_on = s_r.cra[CRA_TONE_OUT] & (~burst_on | (s_nxt.bst == BST_TONE));
        if (!s_r.cra[CRA_IRQ_EN]) begin
            s_nxt.irq_n = 1'b1;
        end else if (s_r.cra[CRA_CP_MODE]) begin
            s_nxt.irq_n = ~cp_square_i;
        end else if (s_r.crb[CRB_TEST]) begin
            s_nxt.irq_n = ~s_nxt.flags[ST_TONE_ABSENT];
        end else begin
            s_nxt.irq_n = ~s_nxt.flags[ST_IRQ];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
            s_r.rd_m <= 1'b1;
            s_r.rd_s <= 1'b1;
            s_r.rd_d <= 1'b1;
            s_r.wr_m <= 1'b1;
            s_r.wr_s <= 1'b1;
            s_r.wr_d <= 1'b1;
            s_r.cra <= DTMFHS_CR_RST;
            s_r.crb <= DTMFHS_CR_RST;
            s_r.flags <= DTMFHS_FLAGS_RST;
            s_r.bst <= BST_IDLE;
            s_r.dout_oe_n <= 1'b1;
            s_r.irq_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign data_o = s_r.dout;
    assign data_oe_n_o = s_r.dout_oe_n;
    assign irq_n_o = s_r.irq_n;
    assign tone_output_enable_o = s_r.tone_on;
    assign tx_code_o = s_r.tx_code;
    assign call_progress_mode_o = s_r.cra[CRA_CP_MODE];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    irq_follows_flags_a: assert property ((s_r.flags[ST_TX_EMPTY] || s_r.flags[ST_RX_FULL])
        |-> s_r.flags[ST_IRQ])
        else $error("interrupt flag low while an event flag is set");
    read_clears_irq_a: assert property ((rd_end && s_r.read_status && s_r.snap == s_r.flags && !rx_set && !tx_set)
        |=> !s_r.flags[ST_IRQ] && !s_r.flags[ST_RX_FULL])
        else $error("status read did not clear seen flags");
    tx_empty_hold_a: assert property (s_r.crb[CRB_BURST_N] |=> !s_r.flags[ST_TX_EMPTY])
        else $error("transmit-empty set outside burst mode");
    pause_end_set_a: assert property ((tx_set && burst_on) |=> s_r.flags[ST_TX_EMPTY] && s_r.bst == BST_IDLE)
        else $error("pause end did not set transmit-empty");
    rx_full_set_a: assert property (rx_set |=> s_r.flags[ST_RX_FULL] && s_r.rx_data == $past(rx_code_i))
        else $error("receive-full or receive data wrong after digit");
    absent_set_a: assert property (tone_absent_i |=> s_r.flags[ST_TONE_ABSENT])
        else $error("tone-absent not set");
    absent_keep_a: assert property ((!tone_valid_i && s_r.flags[ST_TONE_ABSENT]) |=> s_r.flags[ST_TONE_ABSENT])
        else $error("tone-absent cleared without valid tone");
    read_data_a: assert property (rd_start |=> !data_oe_n_o
        && data_o == ($past(s_r.rs_s) ? $past(s_r.flags) : $past(s_r.rx_data)))
        else $error("read returned wrong register");
    bank_switch_a: assert property ((wr_end && s_r.rs_s && s_r.bank_b)
        |=> s_r.crb == $past(s_r.d_s) && !s_r.bank_b && s_r.cra == $past(s_r.cra))
        else $error("control B write misrouted");
    // The write after control B must land in control A again
    bank_return_a: assert property ((wr_end && s_r.rs_s && !s_r.bank_b) |=> s_r.cra == $past(s_r.d_s)
        && s_r.bank_b == $past(s_r.d_s[CRA_BANK_SEL]) && s_r.crb == $past(s_r.crb))
        else $error("control A write misrouted");
    burst_len_a: assert property ((s_r.bst == BST_TONE && s_r.cnt == lim && burst_on)
        |=> s_r.bst == BST_PAUSE && s_r.cnt == '0)
        else $error("burst did not turn to pause at its length");
    irq_pin_a: assert property ((s_r.cra[CRA_IRQ_EN] && !s_r.cra[CRA_CP_MODE] && !s_r.crb[CRB_TEST]
        && $stable(s_r.cra) && $stable(s_r.crb)) |-> irq_n_o == !s_r.flags[ST_IRQ])
        else $error("interrupt pin disagrees with interrupt flag");
    tx_code_a: assert property ((wr_end && !s_r.rs_s) |=> tx_code_o == $past(s_r.d_s))
        else $error("transmit code not taken at write end");
    read_release_a: assert property (rd_end |=> data_oe_n_o)
        else $error("bus still driven after read end");
    read_snap_a: assert property (rd_start |=> s_r.snap == $past(s_r.flags))
        else $error("read snapshot differs from flags");
    // An event in the clearing cycle must survive, or the host never sees it
    late_event_a: assert property ((rd_end && s_r.read_status && rx_set)
        |=> s_r.flags[ST_RX_FULL] && s_r.flags[ST_IRQ])
        else $error("event lost in the read-clear cycle");
    tx_clear_a: assert property ((rd_end && s_r.read_status && s_r.snap[ST_TX_EMPTY] && !tx_set)
        |=> !s_r.flags[ST_TX_EMPTY])
        else $error("transmit-empty survived a status read");
    rx_clear_a: assert property ((rd_end && s_r.read_status && s_r.snap[ST_RX_FULL] && !rx_set)
        |=> !s_r.flags[ST_RX_FULL])
        else $error("receive-full survived a status read");
    absent_clear_a: assert property ((tone_valid_i && !tone_absent_i) |=> !s_r.flags[ST_TONE_ABSENT])
        else $error("tone-absent not cleared by valid tone");
    rx_cp_ignore_a: assert property ((rx_valid_i && s_r.cra[CRA_CP_MODE])
        |=> s_r.rx_data == $past(s_r.rx_data))
        else $error("digit taken in call progress mode");
    // Test mode shows the tone-absent flag on the pin instead of the interrupt flag
    irq_test_a: assert property ((s_r.cra[CRA_IRQ_EN] && !s_r.cra[CRA_CP_MODE] && s_r.crb[CRB_TEST]
        && $stable(s_r.cra) && $stable(s_r.crb)) |-> irq_n_o == !s_r.flags[ST_TONE_ABSENT])
        else $error("interrupt pin disagrees with tone-absent flag in test mode");
    irq_cp_a: assert property ((s_r.cra[CRA_IRQ_EN] && s_r.cra[CRA_CP_MODE] && $stable(s_r.cra))
        |-> irq_n_o == !$past(cp_square_i))
        else $error("interrupt pin does not follow call progress wave");
endmodule : dtmfhs_status_bank

// ==== src/dtmfhs_pkg.sv ====
// Purpose: Constants, state layout and types for the DTMF transceiver host status bank
// Assumes: 10 MHz clk_i; host strobes and select arrive asynchronously on pins
// Notes: Reset clears both control registers, so burst mode is active from reset
package dtmfhs_pkg;
    localparam int DTMFHS_CLK_KHZ = 10000;
    localparam int DTMFHS_BURST_MS = 51;
    localparam int DTMFHS_BURST_CYC = DTMFHS_BURST_MS * DTMFHS_CLK_KHZ;
    localparam int DTMFHS_CNT_W = 21;
    // Status bit positions
    localparam int ST_IRQ = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_RX_FULL = 2;
    localparam int ST_TONE_ABSENT = 3;
    // Control A bit positions
    localparam int CRA_TONE_OUT = 0;
    localparam int CRA_CP_MODE = 1;
    localparam int CRA_IRQ_EN = 2;
    localparam int CRA_BANK_SEL = 3;
    // Control B bit positions; burst bit is active low
    localparam int CRB_BURST_N = 0;
    localparam int CRB_TEST = 1;
    localparam int CRB_SINGLE = 2;
    localparam int CRB_COLUMN = 3;
    localparam logic [3:0] DTMFHS_CR_RST = 4'h0;
    localparam logic [3:0] DTMFHS_FLAGS_RST = 4'h0;

    typedef enum logic [1:0] {BST_IDLE, BST_TONE, BST_PAUSE} dtmfhs_burst_e;

    typedef struct packed {
        logic rs_m, rs_s, rd_m, rd_s, rd_d, wr_m, wr_s, wr_d;
        logic [3:0] d_m, d_s;
        logic [3:0] cra, crb;
        logic bank_b;
        logic [3:0] flags, snap;
        logic read_status;
        logic [3:0] rx_data, tx_code;
        dtmfhs_burst_e bst;
        logic [DTMFHS_CNT_W-1:0] cnt;
        logic [3:0] dout;
        logic dout_oe_n, irq_n, tone_on;
    } dtmfhs_state_s;
endpackage : dtmfhs_pkg

// ==== tb/dtmfhs_host_model.sv ====
// Purpose: Host controller model driving the four-bit strobed register bus
// Assumes: Strobes change just after a rising edge and are held for five clocks
// Notes: An undriven bus shows the inverse of its last value, never a kind default
`timescale 1ns/100ps
module dtmfhs_host_model (
    input wire logic clk_i,
    input wire logic [3:0] dev_data_i,
    input wire logic dev_oe_n_i,
    output logic rs_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [3:0] data_o
);
    logic drive_r;
    logic [3:0] wdata_r;
    logic [3:0] last_r;
    initial begin
        rs_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        drive_r = 1'b0;
        wdata_r = 4'h0;
        last_r = 4'h0;
    end
    always_comb data_o = !dev_oe_n_i ? dev_data_i : (drive_r ? wdata_r : ~last_r);
    always @(posedge clk_i) last_r <= data_o;
    // Long strobe and hold cover the synchroniser delay on the device side
    task automatic access(input logic rs, input logic wr, input logic [3:0] wd, output logic [3:0] rd);
        @(posedge clk_i);
        rs_o <= rs;
        wdata_r <= wd;
        drive_r <= wr;
        rd_n_o <= wr;
        wr_n_o <= !wr;
        repeat (5) @(posedge clk_i);
        rd = data_o;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        drive_r <= 1'b0;
    endtask : access
endmodule : dtmfhs_host_model

// ==== tb/dtmfhs_status_bank_bench.sv ====
// Purpose: Self-checking bench for the host status bank
// Assumes: Burst length shortened to 20 clocks
// Notes: Receiver events are one-clock pulses from the bench
`timescale 1ns/100ps
module dtmfhs_status_bank_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rs, rd_n, wr_n, oe_n, irq_n, tone_en, cp_mode;
    logic [3:0] din, dout, tx_code, v;
    logic rx_valid = 1'b0, absent = 1'b0, present = 1'b0, cp_sq = 1'b0;
    logic [3:0] rx_code = 4'h0;
    int miscompares = 0;
    int compares = 0;
    always #50 clk = ~clk;
    dtmfhs_status_bank #(.BURST_CYC(20)) dut (.clk_i(clk), .nrst_i(nrst), .register_select_input_i(rs),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n), .rx_valid_i(rx_valid),
        .rx_code_i(rx_code), .tone_absent_i(absent), .tone_valid_i(present), .cp_square_i(cp_sq),
        .irq_n_o(irq_n), .tone_output_enable_o(tone_en), .tx_code_o(tx_code), .call_progress_mode_o(cp_mode));
    dtmfhs_host_model hm (.clk_i(clk), .dev_data_i(dout), .dev_oe_n_i(oe_n), .rs_o(rs), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .data_o(din));
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic sel, input logic [3:0] exp, input string what);
        hm.access(sel, 1'b0, 4'h0, v);
        check(what, v, exp);
    endtask : rd
    task automatic wr(input logic sel, input logic [3:0] d);
        hm.access(sel, 1'b1, d, v);
    endtask : wr
    task automatic ev(input logic [2:0] sel, input logic [3:0] code);
        @(posedge clk);
        {rx_valid, absent, present} <= sel;
        rx_code <= code;
        @(posedge clk);
        {rx_valid, absent, present} <= 3'h0;
        #1;
    endtask : ev
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq_n !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        #1;
        check("irq pin", {3'h0, irq_n}, 4'h0);
    endtask : wait_irq
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    initial begin
        #500000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(1'b1, 4'h0, "status after reset");
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        rd(1'b1, 4'h0, "status after init");
        $display("init done");
        wr(1'b1, 4'hd);
        wr(1'b1, 4'h0);
        check("call progress", {3'h0, cp_mode}, 4'h0);
        ev(3'b010, 4'h0);
        rd(1'b1, 4'h8, "absent set");
        rd(1'b1, 4'h8, "absent kept");
        ev(3'b001, 4'h0);
        rd(1'b1, 4'h0, "absent cleared");
        $display("tone absent done");
        wr(1'b0, 4'h7);
        check("tx code", tx_code, 4'h7);
        check("tone on", {3'h0, tone_en}, 4'h1);
        wait_irq();
        rd(1'b1, 4'h3, "tx empty");
        rd(1'b1, 4'h0, "tx empty cleared");
        $display("burst done");
        ev(3'b100, 4'h5);
        wait_irq();
        rd(1'b1, 4'h5, "rx full");
        rd(1'b0, 4'h5, "rx data");
        wr(1'b0, 4'h5);
        check("tx code", tx_code, 4'h5);
        rd(1'b1, 4'h0, "rx full cleared");
        wait_irq();
        rd(1'b1, 4'h3, "second tx empty");
        $display("rx and second digit done");
        fork
            rd(1'b1, 4'h0, "status in race");
            begin
                repeat (7) @(posedge clk);
                ev(3'b100, 4'h9);
            end
        join
        rd(1'b1, 4'h5, "late event kept");
        rd(1'b0, 4'h9, "late rx data");
        $display("read race done");
        wr(1'b1, 4'hd);
        wr(1'b1, 4'h1);
        check("tone steady", {3'h0, tone_en}, 4'h1);
        wr(1'b0, 4'h7);
        repeat (45) @(posedge clk);
        rd(1'b1, 4'h0, "no tx empty outside burst");
        $display("burst off done");
        wr(1'b1, 4'h6);
        check("cp mode on", {3'h0, cp_mode}, 4'h1);
        ev(3'b100, 4'h3);
        rd(1'b1, 4'h0, "rx ignored in cp mode");
        @(posedge clk);
        cp_sq <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("irq pin cp high", {3'h0, irq_n}, 4'h0);
        @(posedge clk);
        cp_sq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("irq pin cp low", {3'h0, irq_n}, 4'h1);
        $display("cp mode done");
        wr(1'b1, 4'hc);
        wr(1'b1, 4'h3);
        ev(3'b010, 4'h0);
        wait_irq();
        ev(3'b001, 4'h0);
        check("irq pin test mode", {3'h0, irq_n}, 4'h1);
        $display("test mode done");
        end_sim();
    end
endmodule : dtmfhs_status_bank_bench
